// >>> dv/rmts_far_model.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Far side: trigger pin, manual button and synthesis cycle ends.
// ---------------------------------------------------------------
module rmts_far_model #(
    parameter int CYC_LEN = 4                // Clocks in one waveform cycle.
) (
    input  wire logic i_core_clk,            // Sample clock.
    input  wire logic i_run,                 // Run level from the sequencer.
    output logic      o_trig_pin,            // External trigger level.
    output logic      o_man_btn,             // Manual button level.
    output logic      o_cycle_end            // One-clock end of cycle pulse.
);
    int phase = 0;                           // Position inside the current cycle.
    initial begin
        o_trig_pin  = 1'b0;
        o_man_btn   = 1'b0;
        o_cycle_end = 1'b0;
    end
    // Synthesis only advances through a cycle while the sequencer runs.
    always @(posedge i_core_clk) begin
        o_cycle_end <= i_run && phase == CYC_LEN - 1;
        phase       <= (i_run && phase < CYC_LEN - 1) ? phase + 1 : 0;
    end
    // The pin moves just after an edge, like any unrelated source.
    task automatic set_pin(input logic v);
        @(posedge i_core_clk);
        o_trig_pin <= v;
    endtask : set_pin
    // A press is a level held long enough to pass the synchroniser.
    task automatic press_button();
        @(posedge i_core_clk);
        o_man_btn <= 1'b1;
        repeat (4) @(posedge i_core_clk);
        o_man_btn <= 1'b0;
    endtask : press_button
endmodule : rmts_far_model

// >>> dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import rmts_pkg::*;
    logic              i_core_clk;           // Sample clock.
    logic              i_arst_n;             // Reset, active low.
    logic [ADDR_W-1:0] i_addr;               // Register address.
    logic [31:0]       i_wdata;              // Write data.
    logic              i_wr;                 // Write strobe.
    logic              i_rd;                 // Read strobe.
    logic [31:0]       o_rdata;              // Read data.
    logic              trig, btn, cend;      // Far-side levels.
    logic              o_run, o_carrier_idle; // Sequencer outputs.
    int                failures = 0;         // Mismatches seen.
    int                comparisons = 0;      // Comparisons made.
    always #50 i_core_clk = ~i_core_clk;
    rmts_sequencer rmts_sequencer_i (.i_core_clk(i_core_clk), .i_arst_n(i_arst_n), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_trig_pin(trig),
        .i_man_btn(btn), .i_cycle_end(cend), .o_run(o_run), .o_carrier_idle(o_carrier_idle));
    rmts_far_model #(.CYC_LEN(4)) rmts_far_model_i (.i_core_clk(i_core_clk), .i_run(o_run),
        .o_trig_pin(trig), .o_man_btn(btn), .o_cycle_end(cend));
    // ---------------------------------------------------------------
    // Bus, compare and wait helpers.
    // ---------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge i_core_clk);
        i_wr <= 1'b1; i_addr <= a; i_wdata <= d;
        @(posedge i_core_clk);
        i_wr <= 1'b0;
    endtask : wr
    // Read data stand only in the cycle after the strobe.
    task automatic rd_chk(input string nm, input logic [ADDR_W-1:0] a, input logic [31:0] exp);
        @(posedge i_core_clk);
        i_rd <= 1'b1; i_addr <= a;
        @(posedge i_core_clk);
        i_rd <= 1'b0;
        #1 chk(nm, exp, o_rdata);
    endtask : rd_chk
    // Counts clocks until the run level reaches lvl; -1 if it never does.
    task automatic wait_run(input logic lvl, input int maxc, output int n);
        n = -1;
        for (int i = 0; i < maxc && n < 0; i++) begin
            @(posedge i_core_clk);
            #1 if (o_run === lvl) n = i;
        end
    endtask : wait_run
    task automatic see(input string nm, input logic lvl, input int maxc, input logic hit);
        int n;
        wait_run(lvl, maxc, n);
        chk(nm, {31'h0, hit}, {31'h0, n >= 0});
    endtask : see
    // ---------------------------------------------------------------
    // Scenarios.
    // ---------------------------------------------------------------
    task automatic t_reset();
        chk("run after reset", 32'h1, {31'h0, o_run});
        rd_chk("ctrl reset", REG_CTRL, 32'h001);
        rd_chk("burst reset", REG_BURST, 32'h1);
        rd_chk("delay reset", REG_DELAY, 32'h2);
        rd_chk("retrigger reset", REG_RETRG, 32'h2);
        rd_chk("unmapped", 4'hf, 32'h0);
        wr(REG_BURST, 32'h0);
        rd_chk("burst low clamp", REG_BURST, 32'h1);
        wr(REG_BURST, 32'h001e8480);
        rd_chk("burst high clamp", REG_BURST, 32'h000f4240);
        wr(REG_CTRL, 32'h023);
        wr(REG_CMD, 32'h1);
        see("continuous holds", 1'b0, 40, 1'b0);
        $display("TEST reset done");
    endtask : t_reset
    task automatic t_burst();
        int k = 0;
        wr(REG_BURST, 32'h3);
        wr(REG_CTRL, 32'h002);
        rmts_far_model_i.set_pin(1'b1);
        see("ext start", 1'b1, 10, 1'b1);
        for (int i = 0; i < 100 && o_run === 1'b1; i++) begin
            @(posedge i_core_clk);
            #1 if (cend === 1'b1) k++;
        end
        chk("burst cycles", 32'h3, k);
        rmts_far_model_i.set_pin(1'b0);
        wr(REG_BURST, 32'h1);
        $display("TEST burst done");
    endtask : t_burst
    task automatic t_sources();
        wr(REG_CTRL, 32'h122);
        @(posedge i_core_clk);
        #1 chk("carrier idle", 32'h1, {31'h0, o_carrier_idle});
        rmts_far_model_i.set_pin(1'b1);
        rmts_far_model_i.press_button();
        see("bus ignores hw", 1'b1, 20, 1'b0);
        wr(REG_CMD, 32'h1);
        see("bus software", 1'b1, 10, 1'b1);
        chk("carrier left", 32'h0, {31'h0, o_carrier_idle});
        see("bus end", 1'b0, 40, 1'b1);
        rmts_far_model_i.set_pin(1'b0);
        wr(REG_CTRL, 32'h042);
        rmts_far_model_i.set_pin(1'b1);
        see("mix unarmed", 1'b1, 20, 1'b0);
        wr(REG_CMD, 32'h1);
        see("mix first", 1'b1, 10, 1'b1);
        see("mix end", 1'b0, 40, 1'b1);
        rmts_far_model_i.set_pin(1'b0);
        rmts_far_model_i.set_pin(1'b1);
        see("mix hardware", 1'b1, 10, 1'b1);
        see("mix end2", 1'b0, 40, 1'b1);
        wr(REG_CTRL, 32'h002);
        wr(REG_CMD, 32'h1);
        see("ext ignores cmd", 1'b1, 20, 1'b0);
        rmts_far_model_i.press_button();
        see("ext button", 1'b1, 10, 1'b1);
        see("ext end", 1'b0, 40, 1'b1);
        $display("TEST sources done");
    endtask : t_sources
    task automatic t_gate_delay();
        int n0;
        int n1;
        wr(REG_CTRL, 32'h018);
        rmts_far_model_i.set_pin(1'b0);
        see("gate open", 1'b1, 10, 1'b1);
        rmts_far_model_i.set_pin(1'b1);
        see("gate stays", 1'b0, 20, 1'b0);
        rmts_far_model_i.set_pin(1'b0);
        see("gate close", 1'b0, 10, 1'b1);
        wr(REG_CTRL, 32'h022);
        wr(REG_CMD, 32'h1);
        wait_run(1'b1, 20, n0);
        see("plain end", 1'b0, 40, 1'b1);
        wr(REG_DELAY, 32'h14);
        wr(REG_CTRL, 32'h026);
        wr(REG_CMD, 32'h1);
        wait_run(1'b1, 60, n1);
        chk("delay ticks", 32'h14, n1 - n0);
        see("delay end", 1'b0, 40, 1'b1);
        $display("TEST gate_delay done");
    endtask : t_gate_delay
    // Two-cycle burst with a five-tick gap between its cycles.
    task automatic t_retrigger();
        int n;
        wr(REG_BURST, 32'h2);
        wr(REG_RETRG, 32'h5);
        rd_chk("retrigger time", REG_RETRG, 32'h5);
        wr(REG_CTRL, 32'h0a2);
        wr(REG_CMD, 32'h1);
        see("retrigger start", 1'b1, 10, 1'b1);
        see("first cycle end", 1'b0, 10, 1'b1);
        wait_run(1'b1, 20, n);
        chk("retrigger gap", 32'h5, n);
        see("second cycle end", 1'b0, 10, 1'b1);
        see("no third cycle", 1'b1, 20, 1'b0);
        wr(REG_BURST, 32'h1);
        $display("TEST retrigger done");
    endtask : t_retrigger
    task automatic close_out();
        $display("COUNTS comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : close_out
    initial begin
        i_core_clk = 1'b0;
        i_arst_n   = 1'b0;
        i_addr     = '0;
        i_wdata    = '0;
        i_wr       = 1'b0;
        i_rd       = 1'b0;
        repeat (10) @(posedge i_core_clk);
        i_arst_n <= 1'b1;
        @(posedge i_core_clk);
        #1 t_reset();
        t_burst();
        t_sources();
        t_gate_delay();
        t_retrigger();
        close_out();
    end
    initial begin
        #(100 * 20000);
        failures++;
        close_out();
    end
endmodule : tb_top

// >>> src/rmts_pkg.sv
package rmts_pkg;

    // ---------------------------------------------------------------
    // Clock and timing figures.
    // ---------------------------------------------------------------
    localparam int unsigned CLK_HZ          = 10_000_000;  // Sample clock rate in hertz.
    localparam int unsigned CLK_PERIOD_NS   = 100;         // Sample clock period in nanoseconds.
    localparam int unsigned MIN_TIME_NS     = 200;         // Least delay and re-trigger time in ns.
    localparam int unsigned MAX_TIME_S      = 20;          // Longest delay and re-trigger time in s.
    // Least time in cycles, rounded up.
    localparam int unsigned MIN_TIME_CYC    = (MIN_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Longest time in cycles, rounded down.
    localparam int unsigned MAX_TIME_CYC    = MAX_TIME_S * CLK_HZ;
    localparam int unsigned TIME_W          = 28;          // Width of a tick count.
    localparam int unsigned EXT_LAT_CYC     = 2;           // Fixed latency of the pin synchroniser.

    // ---------------------------------------------------------------
    // Burst count limits and reset values.
    // ---------------------------------------------------------------
    localparam int unsigned BURST_W         = 20;          // Width of the burst count.
    localparam logic [BURST_W-1:0] BURST_MIN = 20'h00001;  // Least and reset burst count.
    localparam logic [BURST_W-1:0] BURST_MAX = 20'hf4240;  // Largest burst count, one million.

    // ---------------------------------------------------------------
    // Register map of the command port.
    // ---------------------------------------------------------------
    localparam int unsigned ADDR_W          = 4;
    localparam logic [ADDR_W-1:0] REG_CTRL  = 4'h0;        // Mode enables and selections.
    localparam logic [ADDR_W-1:0] REG_BURST = 4'h1;        // Burst cycle count.
    localparam logic [ADDR_W-1:0] REG_DELAY = 4'h2;        // Trigger delay in ticks.
    localparam logic [ADDR_W-1:0] REG_RETRG = 4'h3;        // Re-trigger time in ticks.
    localparam logic [ADDR_W-1:0] REG_CMD   = 4'h4;        // Write-only software trigger.
    localparam logic [ADDR_W-1:0] REG_STAT  = 4'h5;        // Sequencer status.

    // Control register bit positions.
    localparam int unsigned CB_CONT   = 0;                 // Continuous operation.
    localparam int unsigned CB_BURST  = 1;                 // Counted burst enable.
    localparam int unsigned CB_DELAY  = 2;                 // Delayed trigger enable.
    localparam int unsigned CB_GATE   = 3;                 // Gated mode enable.
    localparam int unsigned CB_SLOPE  = 4;                 // One selects the falling edge.
    localparam int unsigned CB_SRC_LO = 5;                 // Source select, two bits.
    localparam int unsigned CB_RETRG  = 7;                 // Re-trigger enable.
    localparam int unsigned CB_MOD    = 8;                 // Modulated waveform selected.
    localparam int unsigned CTRL_W    = 9;
    localparam logic [CTRL_W-1:0] CTRL_RST = 9'h001;       // Continuous on, all else off.

    // Trigger source codes.
    typedef enum logic [1:0] {
        RMTS_SRC_EXT = 2'h0,
        RMTS_SRC_BUS = 2'h1,
        RMTS_SRC_MIX = 2'h2
    } rmts_src_t;

endpackage : rmts_pkg

// >>> src/rmts_sequencer.sv
// Local design decisions: the register addresses and the plain strobed port.
`timescale 1ns/1ps

// Summary of operation
// - Continuous default; interrupted modes then disabled
// - Settings apply only when continuous off
// - Triggered, gated, burst chosen by enables
// - Burst enable makes trigger emit count
// - Burst count 1 to 1M, reset 1
// - Delay enable inserts programmed trigger delay
// - Delay 200ns to 20s, default 200ns
// - External trigger latency fixed, adds delay
// - Modulated output idles on carrier
// - Sources: external pin, manual button, software
// - EXT, BUS, MIX source acceptance rules
// - Slope select; gate toggles per edge
// - Re-trigger waits programmed gap between cycles
// - Gated mode runs only while open
module rmts_sequencer
    import rmts_pkg::*;
(
    input  wire logic              i_core_clk,     // Sample clock, 10 MHz.
    input  wire logic              i_arst_n,       // Asynchronous reset, active low.
    input  wire logic [ADDR_W-1:0] i_addr,         // Register address.
    input  wire logic [31:0]       i_wdata,        // Register write data.
    input  wire logic              i_wr,           // Write strobe.
    input  wire logic              i_rd,           // Read strobe.
    output logic      [31:0]       o_rdata,        // Read data, one cycle after i_rd.
    input  wire logic              i_trig_pin,     // External trigger input, asynchronous.
    input  wire logic              i_man_btn,      // Manual trigger button, debounced level.
    input  wire logic              i_cycle_end,    // Pulse: synthesis finished one waveform cycle.
    output logic                   o_run,          // Output runs waveform cycles while high.
    output logic                   o_carrier_idle  // Modulated output idles on the carrier.
);

    // ---------------------------------------------------------------
    // Configuration registers.
    // ---------------------------------------------------------------
    logic [CTRL_W-1:0]  ctrl_r;       // Mode enables and selections.
    logic [BURST_W-1:0] burst_r;      // Burst cycle count.
    logic [TIME_W-1:0]  delay_r;      // Trigger delay in ticks.
    logic [TIME_W-1:0]  retrg_r;      // Re-trigger time in ticks.
    logic               sw_trig;      // One-cycle software trigger command.

    // Clamp a tick count into the documented time range.
    function automatic logic [TIME_W-1:0] clamp_time(input logic [31:0] v);
        if (v < MIN_TIME_CYC) begin
            clamp_time = TIME_W'(MIN_TIME_CYC);
        end else if (v > MAX_TIME_CYC) begin
            clamp_time = TIME_W'(MAX_TIME_CYC);
        end else begin
            clamp_time = v[TIME_W-1:0];
        end
    endfunction : clamp_time

    // Writes store settings at any time; they steer the sequencer only once continuous is off.
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ctrl_r  <= CTRL_RST;
            burst_r <= BURST_MIN;
            delay_r <= TIME_W'(MIN_TIME_CYC);
            retrg_r <= TIME_W'(MIN_TIME_CYC);
        end else if (i_wr) begin
            case (i_addr)
                REG_CTRL: begin
                    ctrl_r <= i_wdata[CTRL_W-1:0];
                end
                REG_BURST: begin
                    // Out of range counts are clamped to 1 .. 1M.
                    if (i_wdata[BURST_W-1:0] < BURST_MIN || i_wdata[31:BURST_W] != '0) begin
                        burst_r <= (i_wdata[31:BURST_W] != '0) ? BURST_MAX : BURST_MIN;
                    end else if (i_wdata[BURST_W-1:0] > BURST_MAX) begin
                        burst_r <= BURST_MAX;
                    end else begin
                        burst_r <= i_wdata[BURST_W-1:0];
                    end
                end
                REG_DELAY: begin
                    delay_r <= clamp_time(i_wdata);
                end
                REG_RETRG: begin
                    retrg_r <= clamp_time(i_wdata);
                end
                default: begin
                end
            endcase
        end
    end

    // Software trigger is a side effect of a write to the command address.
    assign sw_trig = i_wr && (i_addr == REG_CMD);

    // Decoded controls.
    logic      cont;                    // Continuous operation.
    logic      burst_en;                // Counted burst enable.
    logic      delay_en;                // Delayed trigger enable.
    logic      gate_en;                 // Gated mode enable.
    logic      slope_fall;              // Falling edge sensitive.
    logic      retrg_en;                // Re-trigger enable.
    rmts_src_t src;                     // Trigger source.
    assign cont       = ctrl_r[CB_CONT];
    assign burst_en   = ctrl_r[CB_BURST];
    assign delay_en   = ctrl_r[CB_DELAY];
    assign gate_en    = ctrl_r[CB_GATE];
    assign slope_fall = ctrl_r[CB_SLOPE];
    assign retrg_en   = ctrl_r[CB_RETRG];
    assign src        = rmts_src_t'(ctrl_r[CB_SRC_LO +: 2]);

    // ---------------------------------------------------------------
    // Trigger input conditioning.
    // ---------------------------------------------------------------
    logic [1:0] pin_sync_r;             // Two-stage synchroniser for the trigger pin.
    logic [1:0] btn_sync_r;             // Two-stage synchroniser for the button.
    logic       pin_d_r;                // Previous synchronised pin level.
    logic       btn_d_r;                // Previous synchronised button level.

    // The synchroniser depth is constant, so external latency is fixed.
    // Outside the synchroniser itself, only its second stage is read by any logic.
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            pin_sync_r <= 2'h0;
            btn_sync_r <= 2'h0;
            pin_d_r    <= 1'b0;
            btn_d_r    <= 1'b0;
        end else begin
            pin_sync_r <= {pin_sync_r[0], i_trig_pin};
            btn_sync_r <= {btn_sync_r[0], i_man_btn};
            pin_d_r    <= pin_sync_r[1];
            btn_d_r    <= btn_sync_r[1];
        end
    end

    logic pin_edge;                     // Selected-direction edge on the trigger pin.
    logic btn_edge;                     // Button press.
    logic hw_trig;                      // Any hardware trigger.
    assign pin_edge = slope_fall ? (pin_d_r && !pin_sync_r[1]) : (!pin_d_r && pin_sync_r[1]);
    assign btn_edge = btn_sync_r[1] && !btn_d_r;
    assign hw_trig  = pin_edge || btn_edge;

    // ---------------------------------------------------------------
    // Trigger source acceptance.
    // ---------------------------------------------------------------

    // Mixed mode: hardware triggers stay locked out until a software trigger arrives.
    logic mix_armed_r;                  // Software trigger seen in mixed mode.
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            mix_armed_r <= 1'b0;
        end else if (cont || src != RMTS_SRC_MIX) begin
            mix_armed_r <= 1'b0;
        end else if (sw_trig) begin
            mix_armed_r <= 1'b1;
        end
    end

    // Accepted trigger according to the source selection.
    logic trig_acc;
    always_comb begin
        trig_acc = 1'b0;
        case (src)
            RMTS_SRC_EXT: trig_acc = hw_trig;
            RMTS_SRC_BUS: trig_acc = sw_trig;
            RMTS_SRC_MIX: trig_acc = mix_armed_r ? hw_trig : sw_trig;
            default:      trig_acc = 1'b0;
        endcase
        if (cont) begin
            trig_acc = 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // Sequencer state machine.
    // ---------------------------------------------------------------
    typedef enum logic [2:0] {
        RMTS_IDLE,
        RMTS_DELAY,
        RMTS_RUN,
        RMTS_GAP,
        RMTS_GATE
    } rmts_state_t;

    rmts_state_t        state_r;        // Current state.
    logic [TIME_W-1:0]  tick_r;         // Delay and re-trigger down-counter.
    logic [BURST_W-1:0] left_r;         // Cycles still to emit.

    // Interrupted operation: triggered, gated or burst behaviour.
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state_r <= RMTS_IDLE;
            tick_r  <= '0;
            left_r  <= '0;
        end else if (cont) begin
            state_r <= RMTS_IDLE;
            tick_r  <= '0;
            left_r  <= '0;
        end else begin
            case (state_r)
                RMTS_IDLE: begin
                    if (trig_acc) begin
                        left_r <= burst_en ? burst_r : BURST_MIN;
                        if (gate_en) begin
                            state_r <= RMTS_GATE;
                        end else if (delay_en) begin
                            tick_r  <= delay_r - TIME_W'(1);
                            state_r <= RMTS_DELAY;
                        end else begin
                            state_r <= RMTS_RUN;
                        end
                    end
                end
                RMTS_DELAY: begin
                    // Counter expiry starts the first waveform cycle.
                    if (tick_r == '0) begin
                        state_r <= RMTS_RUN;
                    end else begin
                        tick_r <= tick_r - TIME_W'(1);
                    end
                end
                RMTS_RUN: begin
                    // A cycle end finishes the burst, opens a gap or simply counts down.
                    if (i_cycle_end) begin
                        if (left_r <= BURST_MIN) begin
                            state_r <= RMTS_IDLE;
                        end else begin
                            left_r <= left_r - BURST_MIN;
                            if (retrg_en) begin
                                tick_r  <= retrg_r - TIME_W'(1);
                                state_r <= RMTS_GAP;
                            end
                        end
                    end
                end
                RMTS_GAP: begin
                    // Output stays low while the re-trigger counter runs out.
                    if (tick_r == '0) begin
                        state_r <= RMTS_RUN;
                    end else begin
                        tick_r <= tick_r - TIME_W'(1);
                    end
                end
                RMTS_GATE: begin
                    if (trig_acc || !gate_en) begin
                        state_r <= RMTS_IDLE;
                    end
                end
                default: begin
                    state_r <= RMTS_IDLE;
                end
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Outputs.
    // ---------------------------------------------------------------
    // Output drops on the edge that leaves RUN, whether the burst is done or a
    // re-trigger gap begins, so the gap keeps the output low for retrg_r + 1 cycles.
    logic run_nxt;                      // Next output-run level.
    assign run_nxt = cont
                   || ((state_r == RMTS_RUN || state_r == RMTS_GATE)
                       && !(state_r == RMTS_RUN && i_cycle_end
                            && (left_r <= BURST_MIN || retrg_en))
                       && !(state_r == RMTS_GATE && trig_acc));

    // Output run level is registered; in modulated mode the idle phase is carrier-only.
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_run          <= 1'b0;
            o_carrier_idle <= 1'b0;
        end else begin
            o_run          <= run_nxt;
            o_carrier_idle <= ctrl_r[CB_MOD] && !run_nxt;
        end
    end

    // ---------------------------------------------------------------
    // Register read-back.
    // ---------------------------------------------------------------

    // Read data stands only in the cycle after the read strobe.
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_rdata <= '0;
        end else if (i_rd) begin
            case (i_addr)
                REG_CTRL:  o_rdata <= 32'(ctrl_r);
                REG_BURST: o_rdata <= 32'(burst_r);
                REG_DELAY: o_rdata <= 32'(delay_r);
                REG_RETRG: o_rdata <= 32'(retrg_r);
                REG_STAT:  o_rdata <= {8'h00, 3'(state_r), mix_armed_r, left_r};
                default:   o_rdata <= '0;
            endcase
        end else begin
            o_rdata <= '0;
        end
    end

    // ---------------------------------------------------------------
    // Checks.
    // ---------------------------------------------------------------
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_arst_n);
    // The run check waits one edge after reset, since the output register lags by one.

    cont_runs_a:    assert property (cont && $past(i_arst_n) |=> o_run)
        else $error("Continuous mode did not run output.");
    cont_idle_a:    assert property (cont |=> state_r == RMTS_IDLE)
        else $error("Sequencer left idle in continuous mode.");
    bus_ignore_hw_a: assert property (!cont && src == RMTS_SRC_BUS && !sw_trig |-> !trig_acc)
        else $error("Hardware trigger taken in bus mode.");
    ext_ignore_sw_a: assert property (!cont && src == RMTS_SRC_EXT && !hw_trig |-> !trig_acc)
        else $error("Software trigger taken in external mode.");
    trig_start_a:   assert property (!cont && state_r == RMTS_IDLE && trig_acc && !gate_en
                                     && !delay_en |=> state_r == RMTS_RUN)
        else $error("Trigger did not start a cycle.");
    delay_load_a:   assert property (!cont && state_r == RMTS_IDLE && trig_acc && !gate_en
                                     && delay_en |=> state_r == RMTS_DELAY && tick_r == $past(delay_r) - 1)
        else $error("Delay counter not loaded.");
    delay_count_a:  assert property (!cont && state_r == RMTS_DELAY && tick_r != '0
                                     |=> tick_r == $past(tick_r) - 1)
        else $error("Delay counter did not count down.");
    burst_load_a:   assert property (!cont && state_r == RMTS_IDLE && trig_acc && burst_en
                                     |=> left_r == $past(burst_r))
        else $error("Burst count not loaded.");
    burst_range_a:  assert property (burst_r >= BURST_MIN && burst_r <= BURST_MAX)
        else $error("Burst count out of range.");
    last_idle_a:    assert property (!cont && state_r == RMTS_RUN && i_cycle_end && left_r <= BURST_MIN
                                     |=> state_r == RMTS_IDLE ##0 !o_run)
        else $error("Sequencer did not return to idle.");
    gate_close_a:   assert property (!cont && state_r == RMTS_GATE && trig_acc
                                     |=> state_r == RMTS_IDLE)
        else $error("Gate did not close on edge.");
    gap_entry_a:    assert property (!cont && state_r == RMTS_RUN && i_cycle_end
                                     && left_r > BURST_MIN && retrg_en
                                     |=> state_r == RMTS_GAP && !o_run && tick_r == $past(retrg_r) - 1)
        else $error("Re-trigger gap not entered.");

    burst_cov_c:  cover property (state_r == RMTS_RUN && i_cycle_end && left_r > BURST_MIN);
    delay_cov_c:  cover property (state_r == RMTS_DELAY ##1 state_r == RMTS_RUN);
    gate_cov_c:   cover property (state_r == RMTS_GATE ##1 state_r == RMTS_IDLE);
    retrg_cov_c:  cover property (state_r == RMTS_GAP ##1 state_r == RMTS_RUN);
    mix_cov_c:    cover property (mix_armed_r && trig_acc);

endmodule : rmts_sequencer
